// file: hdl/qpp_quad_port.sv
// bit-configurable four-port pin control block with apb register access
//
// Overview of operation
// R1: config/data bits select hiz, pull-up, drive0, drive1
// R2: four 8-bit ports, each bit independent
// R3: per port: config, data, read-only pin levels
// R4: all wakeup port pins are wakeup sources
// R5: software sets unbonded pins as outputs
// R6: serial input pin is input only
// R7: watchdog selected: pin 1 is watchdog, pull-up
// R8: watchdog deselected: pin 1 is ordinary i/o
// R9: crystal option: pin 7 drives oscillator output
// R10: rc/external: pin 7 input, rising edge wakes
// R11: special data bits 7,6 read zero
// R12: special data bit 7 write enters halt
// R13: special data bit 6 write enters idle
// R14: special config bit 6 selects shift phase
// R15: special config bit 7 enables restart delay (code: only under the rc clock option)
// R16: special port routes alternate function pins
// R17: software leaves the extra port unused
// R18: external irq held high/low one cycle
// R19: timer inputs held high/low one cycle
// R20: factory byte bit 2 low selects watchdog
// R21: factory bits 4,3 select clock option
// R22: pin inputs pass two-stage synchroniser
// R23: reset makes every pin hiz input (pin 1 under watchdog and pin 7 under crystal option are not)
`include "qpp_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module qpp_quad_port #(
  parameter int PORT_W   = 8,   // pins per port
  parameter int NUM_PORT = 4    // number of ports
) (
  input  wire logic                       core_clk_i,          // instruction clock
  input  wire logic                       rst_b_i,             // sync reset, active low
  input  wire logic                       clk_en_i,            // freezes all state when low; reset still clears
  // apb slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [7:0]                 paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic      [31:0]                prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // factory configuration byte, a static strap
  input  wire logic [7:0]                 factory_config_byte_i,
  // pads: input level, output value, output enable, pull-up enable
  input  wire logic [NUM_PORT*PORT_W-1:0] pad_in_i,
  output logic      [NUM_PORT*PORT_W-1:0] pad_out_o,
  output logic      [NUM_PORT*PORT_W-1:0] pad_oe_o,
  output logic      [NUM_PORT*PORT_W-1:0] pad_pullup_o,
  // core-side hooks
  input  wire logic                       watchdog_out_i,      // watchdog output level
  input  wire logic                       osc_drive_i,         // oscillator clock to drive out
  input  wire logic                       so_data_i,           // serial output data
  input  wire logic                       so_en_i,             // serial output active
  input  wire logic                       sk_data_i,           // shift clock out (master)
  input  wire logic                       sk_en_i,             // shift clock driven
  input  wire logic                       tio_data_i,          // timer i/o output value
  input  wire logic                       tio_en_i,            // timer i/o driving
  output logic                            serial_in_o,         // synchronised serial input
  output logic                            shift_clock_pin_o,   // synchronised shift clock pin
  output logic                            timer_io_pin_o,      // synchronised timer i/o pin
  output logic                            timer_capture_pin_o, // synchronised capture pin
  output logic                            ext_irq_pin_o,       // synchronised irq pin
  output logic                            shift_phase_alt_o,   // alternate shift clock phase
  output logic                            restart_delay_enable_o,
  output logic                            halt_req_o,          // one-cycle halt pulse
  output logic                            idle_req_o,          // one-cycle idle pulse
  output logic      [PORT_W-1:0]          wake_src_o,          // wakeup port levels
  output logic                            osc_or_wake_rise_o,  // halt exit pulse
  output logic                            watchdog_sel_o,
  output logic      [1:0]                 clk_opt_o
);

  localparam int ALL_W = NUM_PORT*PORT_W;

  // ------------------------
  // decode helpers
  // both are pure decoders; pin_mode
  // is shared by every pin below
  // ------------------------
  // maps config/data bit pair to pin mode
  function automatic qpp_pkg::qpp_pin_mode_t pin_mode(input logic cfg, input logic dat);
    qpp_pkg::qpp_pin_mode_t m;
    case ({cfg, dat})
      2'b00:   m = qpp_pkg::QPP_PIN_HIZ;    // R1
      2'b01:   m = qpp_pkg::QPP_PIN_PULLUP; // R1
      2'b10:   m = qpp_pkg::QPP_PIN_DRIVE0; // R1
      default: m = qpp_pkg::QPP_PIN_DRIVE1; // R1
    endcase
    return m;
  endfunction

  // maps factory clock bits to the clock option
  function automatic qpp_pkg::qpp_clk_opt_t clk_decode(input logic [1:0] b);
    qpp_pkg::qpp_clk_opt_t o;
    case (b)
      2'b00:   o = qpp_pkg::QPP_CLK_EXTERNAL; // R21
      2'b01:   o = qpp_pkg::QPP_CLK_RC;       // R21
      default: o = qpp_pkg::QPP_CLK_CRYSTAL;  // R21
    endcase
    return o;
  endfunction

  // ------------------------
  // registers
  // one flop bank per concern,
  // strap flops kept out of reset
  // ------------------------
  logic [PORT_W-1:0] cfg_reg  [NUM_PORT];  // pin_direction_config per port
  logic [PORT_W-1:0] data_reg [NUM_PORT];  // pin_output_value per port
  logic [ALL_W-1:0]  sync1_reg;            // first synchroniser stage
  logic [ALL_W-1:0]  sync2_reg;            // second stage, the only reader
  logic              osc_wake_dly_reg;     // previous pin 7 level for edges
  logic              halt_req_reg;
  logic              idle_req_reg;
  logic              fcb_wdog_reg;         // caught strap bits
  logic [1:0]        fcb_clk_reg;
  logic [31:0]       prdata_reg;

  qpp_pkg::qpp_clk_opt_t clk_opt;

  // ------------------------
  // apb decode
  // single cycle slave, no wait
  // states, so no bus state machine
  // ------------------------
  logic        apb_acc;       // access phase, answered at once
  logic        apb_wr;
  logic [1:0]  acc_port;
  logic [7:0]  acc_ofs;
  logic        port_hit;
  logic        stat_hit;

  assign apb_acc  = psel_i && penable_i;
  assign apb_wr   = apb_acc && pwrite_i;
  assign acc_port = paddr_i[5:4];
  assign acc_ofs  = {4'h0, paddr_i[3:0]};
  // three words per port, status word after the ports
  assign port_hit = (paddr_i[7:6] == 2'b00) && (paddr_i[1:0] == 2'b00) &&
                    ((acc_ofs == `QPP_CFG_OFS) || (acc_ofs == `QPP_DATA_OFS) ||
                     (acc_ofs == `QPP_PIN_OFS));
  assign stat_hit = (paddr_i == `QPP_STATUS_OFS);

  // zero wait states, error only on unmapped addresses
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_acc && !port_hit && !stat_hit;
  assign prdata_o  = prdata_reg;

  // ------------------------
  // strap capture: clocked, loaded from a port even while reset is low
  // straps only move in test; live
  // resampling costs three flops
  // ------------------------
  always_ff @(posedge core_clk_i) begin
    if (clk_en_i) begin
      fcb_wdog_reg <= factory_config_byte_i[`QPP_FCB_WDOG];  // R20
      fcb_clk_reg  <= {factory_config_byte_i[`QPP_FCB_CLK_HI],
                       factory_config_byte_i[`QPP_FCB_CLK_LO]}; // R21
    end
  end

  assign clk_opt        = clk_decode(fcb_clk_reg);
  assign watchdog_sel_o = !fcb_wdog_reg;   // R20
  assign clk_opt_o      = clk_opt;

  // ------------------------
  // configuration and data registers, written a whole byte at a time
  // writes land in the access
  // cycle, one byte per word
  // ------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      for (int p = 0; p < NUM_PORT; p++) begin
        cfg_reg[p]  <= `QPP_CFG_RST;   // R23
        data_reg[p] <= `QPP_DATA_RST;  // R23
      end
    end else if (clk_en_i && apb_wr && port_hit) begin
      // R2 R3
      if (acc_ofs == `QPP_CFG_OFS) begin
        cfg_reg[acc_port] <= pwdata_i[PORT_W-1:0];
      end else if (acc_ofs == `QPP_DATA_OFS) begin
        data_reg[acc_port] <= pwdata_i[PORT_W-1:0];
      end
    end
  end

  // ------------------------
  // halt and idle requests: spare data bits act as triggers
  // pulses, not levels: the core
  // latches the mode itself
  // ------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      halt_req_reg <= 1'b0;
      idle_req_reg <= 1'b0;
    end else if (clk_en_i) begin
      halt_req_reg <= 1'b0;
      idle_req_reg <= 1'b0;
      if (apb_wr && port_hit && acc_port == `QPP_PORT_SPECIAL &&
          acc_ofs == `QPP_DATA_OFS) begin
        halt_req_reg <= pwdata_i[`QPP_BIT_OSC]; // R12
        idle_req_reg <= pwdata_i[`QPP_BIT_SI];  // R13
      end
    end
  end

  assign halt_req_o = halt_req_reg;
  assign idle_req_o = idle_req_reg;

  // ------------------------
  // input synchroniser and halt-exit edge
  // pin 7 edge uses the second
  // stage only, never the first
  // ------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sync1_reg        <= '0;
      sync2_reg        <= '0;
      osc_wake_dly_reg <= 1'b0;
    end else if (clk_en_i) begin
      sync1_reg        <= pad_in_i;   // R22
      sync2_reg        <= sync1_reg;  // R22
      osc_wake_dly_reg <= sync2_reg[`QPP_PORT_SPECIAL*PORT_W+`QPP_BIT_OSC];
    end
  end

  // rising edge only counts when pin 7 is an input
  assign osc_or_wake_rise_o = (clk_opt != qpp_pkg::QPP_CLK_CRYSTAL) &&
      sync2_reg[`QPP_PORT_SPECIAL*PORT_W+`QPP_BIT_OSC] && !osc_wake_dly_reg; // R10

  // ------------------------
  // read mux, registered so data leaves a flip-flop
  // costs a decode in the setup
  // cycle instead of the access
  // ------------------------
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      prdata_reg <= 32'h0000_0000;
    end else if (clk_en_i && psel_i && !penable_i && !pwrite_i) begin
      // loaded in setup so it is valid throughout the access phase
      prdata_reg <= 32'h0000_0000;
      if (paddr_i == `QPP_STATUS_OFS) begin
        prdata_reg <= {27'h0, restart_delay_enable_o, shift_phase_alt_o,
                       fcb_clk_reg, watchdog_sel_o};
      end else if (paddr_i[7:6] == 2'b00) begin
        case ({4'h0, paddr_i[3:0]})
          `QPP_CFG_OFS:  prdata_reg[PORT_W-1:0] <= cfg_reg[paddr_i[5:4]];
          `QPP_DATA_OFS: begin
            prdata_reg[PORT_W-1:0] <= data_reg[paddr_i[5:4]];
            if (paddr_i[5:4] == `QPP_PORT_SPECIAL) begin
              prdata_reg[`QPP_BIT_OSC] <= 1'b0;  // R11
              prdata_reg[`QPP_BIT_SI]  <= 1'b0;  // R11
            end
          end
          `QPP_PIN_OFS:  prdata_reg[PORT_W-1:0] <=
                           sync2_reg[paddr_i[5:4]*PORT_W +: PORT_W]; // R3
          default:       prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ------------------------
  // special port control bits
  // both live in the special
  // port configuration register
  // ------------------------
  assign shift_phase_alt_o      = cfg_reg[`QPP_PORT_SPECIAL][`QPP_BIT_SI];  // R14
  assign restart_delay_enable_o = cfg_reg[`QPP_PORT_SPECIAL][`QPP_BIT_OSC] &&
                                  (clk_opt == qpp_pkg::QPP_CLK_RC);         // R15

  // ------------------------
  // alternate input and wakeup routing from the synchronised special and wakeup ports
  // hooks see a pin two edges
  // after the pad moved
  // ------------------------
  localparam int SB = `QPP_PORT_SPECIAL*PORT_W;
  assign serial_in_o         = sync2_reg[SB+`QPP_BIT_SI];      // R16
  assign shift_clock_pin_o   = sync2_reg[SB+`QPP_BIT_SK];      // R16
  assign timer_io_pin_o      = sync2_reg[SB+`QPP_BIT_TIO];     // R16 R19
  assign timer_capture_pin_o = sync2_reg[SB+`QPP_BIT_TCAP];    // R16 R19
  assign ext_irq_pin_o       = sync2_reg[SB+`QPP_BIT_EXT_IRQ]; // R16 R18
  assign wake_src_o          = sync2_reg[`QPP_PORT_WAKE*PORT_W +: PORT_W]; // R4

  // ------------------------
  // pad drivers, one set per pin
  // alternate hooks override the
  // plain gpio set-up
  // ------------------------
  genvar gp, gb;
  generate
    for (gp = 0; gp < NUM_PORT; gp++) begin : g_port
      for (gb = 0; gb < PORT_W; gb++) begin : g_bit
        qpp_pkg::qpp_pin_mode_t mode;
        logic out_v, oe_v, pu_v;
        assign mode = pin_mode(cfg_reg[gp][gb], data_reg[gp][gb]);
        always_comb begin
          // ordinary gpio set-up by default
          out_v = (mode == qpp_pkg::QPP_PIN_DRIVE1);                // R1
          oe_v  = (mode == qpp_pkg::QPP_PIN_DRIVE0) ||
                  (mode == qpp_pkg::QPP_PIN_DRIVE1);                // R1 R2
          pu_v  = (mode == qpp_pkg::QPP_PIN_PULLUP);                // R1
          if (gp == `QPP_PORT_SPECIAL) begin
            if (gb == `QPP_BIT_SI) begin
              out_v = 1'b0;                                         // R6
              oe_v  = 1'b0;                                         // R6
              pu_v  = 1'b0;
            end else if (gb == `QPP_BIT_OSC) begin
              // spare bits steer modes, never the pin
              out_v = (clk_opt == qpp_pkg::QPP_CLK_CRYSTAL) && osc_drive_i; // R9
              oe_v  = (clk_opt == qpp_pkg::QPP_CLK_CRYSTAL);              // R9 R10
              pu_v  = 1'b0;                                               // R10
            end else if (gb == `QPP_BIT_WDOG && watchdog_sel_o) begin
              // low drive, weak pull-up for high; config bit ignored
              out_v = 1'b0;                                         // R7
              oe_v  = !watchdog_out_i;                              // R7
              pu_v  = watchdog_out_i;                               // R7
            end else if (gb == `QPP_BIT_SO && so_en_i) begin
              out_v = so_data_i;                                    // R16
              oe_v  = 1'b1;
            end else if (gb == `QPP_BIT_SK && sk_en_i) begin
              out_v = sk_data_i;                                    // R16
              oe_v  = 1'b1;
            end else if (gb == `QPP_BIT_TIO && tio_en_i) begin
              out_v = tio_data_i;                                   // R16
              oe_v  = 1'b1;
            end
            // pin 1 without watchdog stays plain gpio            R8
          end
        end
        assign pad_out_o[gp*PORT_W+gb]    = out_v;
        assign pad_oe_o[gp*PORT_W+gb]     = oe_v;
        assign pad_pullup_o[gp*PORT_W+gb] = pu_v;
      end
    end
  endgenerate

endmodule

`default_nettype wire

// file: pkg/qpp_consts.svh
// register offsets, port numbers, field positions and reset values for the quad port block
`ifndef QPP_CONSTS_SVH
`define QPP_CONSTS_SVH
// ------------------------
// register map, one aligned word each, three per port
// ------------------------
`define QPP_PORT_STRIDE     8'h10
`define QPP_CFG_OFS         8'h00
`define QPP_DATA_OFS        8'h04
`define QPP_PIN_OFS         8'h08
`define QPP_STATUS_OFS      8'h40
// ------------------------
// port numbers and special port bit positions
// ------------------------
`define QPP_PORT_WAKE       2'd0
`define QPP_PORT_SPECIAL    2'd1
`define QPP_BIT_EXT_IRQ     0
`define QPP_BIT_WDOG        1
`define QPP_BIT_TCAP        2
`define QPP_BIT_TIO         3
`define QPP_BIT_SO          4
`define QPP_BIT_SK          5
`define QPP_BIT_SI          6
`define QPP_BIT_OSC         7
// ------------------------
// factory configuration byte fields
// ------------------------
`define QPP_FCB_WDOG        2
`define QPP_FCB_CLK_HI      4
`define QPP_FCB_CLK_LO      3
// ------------------------
// reset values
// ------------------------
`define QPP_CFG_RST         8'h00
`define QPP_DATA_RST        8'h00
`endif

// file: pkg/qpp_pkg.sv
// types shared by the quad port block
package qpp_pkg;
  // clock source selected by the factory configuration byte
  typedef enum logic [1:0] {
    QPP_CLK_EXTERNAL,
    QPP_CLK_RC,
    QPP_CLK_CRYSTAL
  } qpp_clk_opt_t;
  // pin set-up derived from configuration and data bit
  typedef enum logic [1:0] {
    QPP_PIN_HIZ,
    QPP_PIN_PULLUP,
    QPP_PIN_DRIVE0,
    QPP_PIN_DRIVE1
  } qpp_pin_mode_t;
endpackage

// file: test/qpp_pin_world.sv
// board-side circuit model on the port pins
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// pin level resolution
// ----------------------------------------------------------------------------
module qpp_pin_world (
  input  wire logic        core_clk_i,   // only paces the floating pattern
  input  wire logic [31:0] pad_out_i,    // block output value
  input  wire logic [31:0] pad_oe_i,     // block drives pin
  input  wire logic [31:0] pad_pullup_i, // block weak pull-up
  input  wire logic [31:0] ext_val_i,    // board drive value
  input  wire logic [31:0] ext_en_i,     // board drives pin
  output logic      [31:0] pad_level_o   // resolved level
);
  logic flip_reg = 1'b0; // floating pins wander every cycle
  // pattern for undriven pins, so nothing reads a stale level
  always_ff @(posedge core_clk_i) begin
    flip_reg <= !flip_reg;
  end
  // block drive wins, then board, then pull-up, else float
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      if (pad_oe_i[i]) begin
        pad_level_o[i] = pad_out_i[i];
      end else if (ext_en_i[i]) begin
        pad_level_o[i] = ext_val_i[i];
      end else if (pad_pullup_i[i]) begin
        pad_level_o[i] = 1'b1;
      end else begin
        pad_level_o[i] = flip_reg ^ i[0];
      end
    end
  end
endmodule
`default_nettype wire

// file: test/qpp_quad_port_asserts.sv
// port-level checker for the quad port pin block
`include "qpp_consts.svh"
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------------------
// checker module
// ----------------------------------------------------------------------------
module qpp_quad_port_asserts #(
  parameter int PORT_W   = 8,
  parameter int NUM_PORT = 4,
  parameter int ALL_W    = NUM_PORT*PORT_W
) (
  input wire logic              core_clk_i,
  input wire logic              rst_b_i,
  input wire logic              psel_i,
  input wire logic              penable_i,
  input wire logic              pwrite_i,
  input wire logic [7:0]        paddr_i,
  input wire logic [31:0]       pwdata_i,
  input wire logic              pslverr_o,
  input wire logic [7:0]        factory_config_byte_i,
  input wire logic [ALL_W-1:0]  pad_in_i,
  input wire logic [ALL_W-1:0]  pad_out_o,
  input wire logic [ALL_W-1:0]  pad_oe_o,
  input wire logic [ALL_W-1:0]  pad_pullup_o,
  input wire logic              watchdog_out_i,
  input wire logic              osc_drive_i,
  input wire logic              halt_req_o,
  input wire logic              idle_req_o,
  input wire logic [PORT_W-1:0] wake_src_o,
  input wire logic              ext_irq_pin_o,
  input wire logic              osc_or_wake_rise_o,
  input wire logic              watchdog_sel_o,
  input wire logic [1:0]        clk_opt_o
);
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  logic wr_sp;  // write of the special data word
  logic mapped; // address decodes to a register
  logic xtal;   // crystal option in force
  assign wr_sp = psel_i && penable_i && pwrite_i && paddr_i == 8'h14;
  assign mapped = paddr_i == 8'h40 ||
                  (paddr_i[7:6] == 2'b00 && paddr_i[3:0] inside {4'h0, 4'h4, 4'h8});
  assign xtal = clk_opt_o == qpp_pkg::QPP_CLK_CRYSTAL;
  // ---------------------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------------------
  property p_mode_excl; (pad_oe_o & pad_pullup_o) == '0; endproperty
  a_mode_excl: assert property (p_mode_excl) else $error("pin driven and pulled");
  property p_si_in; pad_oe_o[14] == 1'b0; endproperty
  a_si_in: assert property (p_si_in) else $error("serial input pin driven");
  property p_halt; wr_sp && pwdata_i[7] |=> halt_req_o; endproperty
  a_halt: assert property (p_halt) else $error("no halt pulse");
  property p_idle; wr_sp && pwdata_i[6] |=> idle_req_o ##1 !idle_req_o; endproperty
  a_idle: assert property (p_idle) else $error("idle pulse wrong");
  property p_wdog;
    watchdog_sel_o |-> pad_oe_o[9] == !watchdog_out_i && !pad_out_o[9] &&
                       pad_pullup_o[9] == watchdog_out_i;
  endproperty
  a_wdog: assert property (p_wdog) else $error("watchdog pin wrong");
  property p_xtal; xtal |-> pad_oe_o[15] && pad_out_o[15] == osc_drive_i; endproperty
  a_xtal: assert property (p_xtal) else $error("oscillator pin not driven");
  property p_g7in; !xtal |-> !pad_oe_o[15] && !pad_pullup_o[15]; endproperty
  a_g7in: assert property (p_g7in) else $error("wake pin not hiz");
  property p_rise;
    osc_or_wake_rise_o |-> !xtal && $past(pad_in_i[15], 2) && !$past(pad_in_i[15], 3);
  endproperty
  a_rise: assert property (p_rise) else $error("spurious wake rise");
  property p_sync;
    $past(rst_b_i) && $past(rst_b_i, 2) |->
      wake_src_o == $past(pad_in_i[7:0], 2) && ext_irq_pin_o == $past(pad_in_i[8], 2);
  endproperty
  a_sync: assert property (p_sync) else $error("input sync delay wrong");
  property p_wsel;
    $past(rst_b_i) |-> watchdog_sel_o == !$past(factory_config_byte_i[2]);
  endproperty
  a_wsel: assert property (p_wsel) else $error("watchdog select wrong");
  property p_copt;
    $past(rst_b_i) |-> clk_opt_o == ($past(factory_config_byte_i[4]) ? 2'd2 :
                                     {1'b0, $past(factory_config_byte_i[3])});
  endproperty
  a_copt: assert property (p_copt) else $error("clock option wrong");
  property p_err;
    psel_i && penable_i && paddr_i[1:0] == 2'b00 |-> pslverr_o == !mapped;
  endproperty
  a_err: assert property (p_err) else $error("slave error wrong");
  c_halt: cover property (halt_req_o);
  c_rise: cover property (osc_or_wake_rise_o);
  c_err: cover property (pslverr_o);
endmodule
bind qpp_quad_port qpp_quad_port_asserts #(.PORT_W(PORT_W), .NUM_PORT(NUM_PORT))
  qpp_quad_port_asserts_inst (.core_clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
  .pwdata_i, .pslverr_o, .factory_config_byte_i, .pad_in_i, .pad_out_o, .pad_oe_o,
  .pad_pullup_o, .watchdog_out_i, .osc_drive_i, .halt_req_o, .idle_req_o, .wake_src_o,
  .ext_irq_pin_o, .osc_or_wake_rise_o, .watchdog_sel_o, .clk_opt_o);
`default_nettype wire

// file: test/testbench.sv
// self-checking bench for the quad port pin block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        core_clk_i = 1'b0, rst_b_i = 1'b0;
  logic        psel_i = 1'b0, penable_i = 1'b0, pwrite_i = 1'b0, rerr;
  logic [7:0]  paddr_i = 8'h00, fcb = 8'h08, s;
  logic [31:0] pwdata_i = '0, ext_val = '0, ext_en = 32'h0000_8000, rdat;
  logic        wd_out = 1'b1, osc_drv = 1'b1, so_d = 1'b0, so_e = 1'b0;
  logic        sk_d = 1'b0, sk_e = 1'b0, tio_d = 1'b0, tio_e = 1'b0, wd_on, xt;
  logic [31:0] prdata, pad_out, pad_oe, pad_pull, pad_lvl;
  logic        pready, pslverr, si, skp, tiop, tcap, irq, alt, rdly, halt, idle, rise, wsel;
  logic [7:0]  wake;
  logic [1:0]  copt;
  logic [7:0]  straps [4] = '{8'h1c, 8'h04, 8'h10, 8'h08}; // crystal, ext, crystal, rc
  int          n_mismatch = 0, cmp_count = 0;
  // ---------------------------------------------------------------------------
  // design and board model
  // ---------------------------------------------------------------------------
  qpp_quad_port qpp_quad_port_inst (.core_clk_i, .rst_b_i, .clk_en_i(1'b1), .psel_i,
    .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .factory_config_byte_i(fcb), .pad_in_i(pad_lvl), .pad_out_o(pad_out),
    .pad_oe_o(pad_oe), .pad_pullup_o(pad_pull), .watchdog_out_i(wd_out), .osc_drive_i(osc_drv),
    .so_data_i(so_d), .so_en_i(so_e), .sk_data_i(sk_d), .sk_en_i(sk_e), .tio_data_i(tio_d),
    .tio_en_i(tio_e), .serial_in_o(si), .shift_clock_pin_o(skp), .timer_io_pin_o(tiop),
    .timer_capture_pin_o(tcap), .ext_irq_pin_o(irq), .shift_phase_alt_o(alt),
    .restart_delay_enable_o(rdly), .halt_req_o(halt), .idle_req_o(idle), .wake_src_o(wake),
    .osc_or_wake_rise_o(rise), .watchdog_sel_o(wsel), .clk_opt_o(copt));
  qpp_pin_world qpp_pin_world_inst (.core_clk_i, .pad_out_i(pad_out), .pad_oe_i(pad_oe),
    .pad_pullup_i(pad_pull), .ext_val_i(ext_val), .ext_en_i(ext_en), .pad_level_o(pad_lvl));
  // 8 ns clock
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  // ---------------------------------------------------------------------------
  // verdict, compare and bus tasks
  // ---------------------------------------------------------------------------
  task results;
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      n_mismatch++;
      results();
    end
    rdat = prdata;
    rerr = pslverr;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  // ---------------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    for (int p = 0; p < 4; p++) begin
      apb(1'b0, 8'(16 * p), '0);
      chk(rdat, '0);
      apb(1'b0, 8'(16 * p + 4), '0);
      chk(rdat, '0);
    end
    @(negedge core_clk_i);
    chk(pad_oe, '0);
    chk(pad_pull & ~32'h0000_0200, '0);
    // mixed set-up per bit on the plain ports
    foreach (straps[p]) begin
      if (p != 1) begin
        apb(1'b1, 8'(16 * p), 32'hcc);
        apb(1'b1, 8'(16 * p + 4), 32'haa);
        @(negedge core_clk_i);
        chk(pad_oe[8*p+:8], 8'hcc);
        chk(pad_out[8*p+:8] & 8'hcc, 8'h88);
        chk(pad_pull[8*p+:8], 8'h22);
        apb(1'b0, 8'(16 * p), '0);
        chk(rdat, 32'hcc);
      end
    end
    apb(1'b0, 8'h28, '0);
    chk(rdat & 32'hee, 32'haa);
    apb(1'b1, 8'h00, '0);
    apb(1'b1, 8'h30, '0);
    ext_en <= 32'hff00_80ff;
    ext_val <= 32'h3c00_005a;
    repeat (3) @(negedge core_clk_i);
    chk(wake, 8'h5a);
    apb(1'b0, 8'h08, '0);
    chk(rdat, 32'h5a);
    apb(1'b1, 8'h38, 32'hff);
    apb(1'b0, 8'h38, '0);
    chk(rdat, 32'h3c);
    // special port bits
    apb(1'b1, 8'h14, 32'hc2);
    @(negedge core_clk_i);
    chk({halt, idle}, 2'b11);
    @(negedge core_clk_i);
    chk({halt, idle}, 2'b00);
    apb(1'b0, 8'h14, '0);
    chk(rdat, 32'h02);
    apb(1'b1, 8'h10, 32'hc2);
    @(negedge core_clk_i);
    chk({alt, rdly}, 2'b11);
    // every clock option and watchdog choice
    foreach (straps[i]) begin
      s = straps[i];
      wd_on = !s[2];
      xt = s[4];
      @(posedge core_clk_i);
      fcb <= s;
      repeat (2) @(negedge core_clk_i);
      chk(wsel, wd_on);
      chk(copt, xt ? 32'd2 : {31'd0, s[3]});
      chk({pad_oe[9], pad_pull[9]}, wd_on ? 2'b01 : 2'b10);
      chk({pad_oe[15], pad_out[15] & xt}, {xt, xt});
      chk(rdly, s[4:3] == 2'b01);
      apb(1'b0, 8'h40, '0);
      chk(rdat, {27'd0, s[4:3] == 2'b01, 1'b1, s[4], s[3], wd_on});
    end
    // alternate function routing
    so_e <= 1'b1;
    wd_out <= 1'b0;
    so_d <= 1'b1;
    sk_e <= 1'b1;
    tio_e <= 1'b1;
    tio_d <= 1'b1;
    ext_en <= 32'hff00_c5ff;
    ext_val <= 32'h3c00_c15a;
    repeat (3) @(negedge core_clk_i);
    chk({pad_oe[13:11], pad_out[13:11]}, 6'b111_011);
    chk({skp, tiop, si, tcap, irq}, 5'b01101);
    chk({pad_oe[9], pad_pull[9], pad_out[9]}, 3'b100);
    chk(rise, 1'b1);
    apb(1'b0, 8'h50, '0);
    chk({rerr, rdat}, {1'b1, 32'h0});
    results();
  end
  // hang guard
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
endmodule
`default_nettype wire
